/* File: pspc_top.sv */
// start-up protocol selection, switch decode, led codes and per-port mode store
// assumes apb from the network controller, async switch and supply pins,
// and a nonvolatile store on this clock that reports erase completion
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pspc_top #(
  parameter int BLINK_CYC = pspc_pkg::BLINK_CYC
) (
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [11:0]              PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  input  wire pspc_pkg::pspc_sw_s       SWITCHES,
  input  wire logic                     US_OK,
  input  wire logic                     NV_PROTO_VALID,
  input  wire pspc_pkg::pspc_proto_e    NV_PROTO,
  input  wire logic                     NV_CFG_VALID,
  input  wire pspc_pkg::pspc_cfg_s [7:0] NV_CFG,
  input  wire logic                     NV_DONE,
  output logic                          NV_WR_PROTO,
  output pspc_pkg::pspc_proto_e         NV_PROTO_WDATA,
  output logic                          NV_WR_CFG,
  output pspc_pkg::pspc_cfg_s [7:0]     NV_CFG_WDATA,
  output logic                          NV_ERASE,
  output pspc_pkg::pspc_proto_e         PROTO_ACTIVE,
  output pspc_pkg::pspc_sw_s            IP_DIGITS,
  output logic                          IP_VALID,
  output pspc_pkg::pspc_cfg_s [7:0]     PORT_CFG,
  output logic      [7:0]               PORT_SUPPLY_EN,
  output logic      [7:0]               PORT_IOL_START,
  output logic                          PORT_DATA_VALID,
  output logic                          FAULT_STATUS_LED_RED,
  output logic                          SUPPLY_LED_RED,
  output logic                          SUPPLY_LED_GREEN,
  output logic                          IRQ
);

  typedef enum logic [2:0] {
    ST_DEB  = 3'b000,
    ST_DEC  = 3'b001,
    ST_RUN  = 3'b011,
    ST_FRST = 3'b010,
    ST_ERR  = 3'b110
  } pspc_state_e;

  function automatic pspc_pkg::pspc_proto_e decode(input pspc_pkg::pspc_sw_s s);
    decode = pspc_pkg::PR_NONE;
    if (s.hund <= pspc_pkg::POS_EIP_MAX) begin
      decode = pspc_pkg::PR_EIP;
    end else if (s.hund == pspc_pkg::POS_PN) begin
      decode = pspc_pkg::PR_PN;
    end else if (s.hund == pspc_pkg::POS_EC) begin
      decode = pspc_pkg::PR_EC;
    end else if (s.hund == pspc_pkg::POS_MB) begin
      decode = pspc_pkg::PR_MB;
    end else if (s.hund == pspc_pkg::POS_CC) begin
      decode = pspc_pkg::PR_CC;
    end
  endfunction : decode

  function automatic logic uses_ip(input pspc_pkg::pspc_proto_e p);
    uses_ip = (p == pspc_pkg::PR_EIP) || (p == pspc_pkg::PR_MB) || (p == pspc_pkg::PR_CC);
  endfunction : uses_ip

  // three-stage pin synchronisers; stage one feeds stage two only
  pspc_pkg::pspc_sw_s sw_s1_r, sw_s2_r, sw_s3_r;
  logic               us_s1_r, us_s2_r, us_s3_r, us_r;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sw_s1_r <= '0;
      sw_s2_r <= '0;
      sw_s3_r <= '0;
      us_s1_r <= 1'b0;
      us_s2_r <= 1'b0;
      us_s3_r <= 1'b0;
    end else begin
      sw_s1_r <= SWITCHES;
      sw_s2_r <= sw_s1_r;
      sw_s3_r <= sw_s2_r;
      us_s1_r <= US_OK;
      us_s2_r <= us_s1_r;
      us_s3_r <= us_s2_r;
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      us_r <= 1'b0;
    end else if (us_s2_r == us_s3_r) begin
      us_r <= us_s3_r;
    end
  end

  // apb decode
  wire        apb_setup = PSEL & ~PENABLE;
  wire        apb_acc   = PSEL & PENABLE & PREADY;
  wire        apb_wr    = apb_acc & PWRITE;
  wire        apb_rd    = apb_acc & ~PWRITE;
  wire        hit_ctrl  = PADDR == pspc_pkg::A_CTRL;
  wire        hit_stat  = PADDR == pspc_pkg::A_STAT;
  wire        hit_irqs  = PADDR == pspc_pkg::A_IRQS;
  wire        hit_irqm  = PADDR == pspc_pkg::A_IRQM;
  wire        hit_ip    = PADDR == pspc_pkg::A_IPADR;
  wire [11:0] pcfg_off  = PADDR - pspc_pkg::A_PCFG;
  wire        hit_pcfg  = (PADDR >= pspc_pkg::A_PCFG) && (pcfg_off < 12'h020) && (PADDR[1:0] == 2'h0);
  wire [2:0]  pcfg_idx  = pcfg_off[4:2];
  wire        hit_any   = hit_ctrl | hit_stat | hit_irqs | hit_irqm | hit_ip | hit_pcfg;

  // incoming port configuration and its length check
  pspc_pkg::pspc_cfg_s wr_cfg;
  assign wr_cfg.mode    = pspc_pkg::pspc_mode_e'(PWDATA[pspc_pkg::PCFG_MODE_LSB +: 2]);
  assign wr_cfg.in_len  = PWDATA[pspc_pkg::PCFG_IN_LSB +: 6];
  assign wr_cfg.out_len = PWDATA[pspc_pkg::PCFG_OUT_LSB +: 6];
  wire len_ok = (wr_cfg.in_len >= pspc_pkg::LEN_MIN) && (wr_cfg.in_len <= pspc_pkg::IN_LEN_MAX)
             && (wr_cfg.out_len >= pspc_pkg::LEN_MIN) && (wr_cfg.out_len <= pspc_pkg::OUT_LEN_MAX);
  wire cfg_ok = (wr_cfg.mode != pspc_pkg::MD_IOL) || len_ok;
  wire web_rst  = apb_wr & hit_ctrl & PWDATA[pspc_pkg::CTRL_WEBRST];
  wire cyc_strt = apb_wr & hit_ctrl & PWDATA[pspc_pkg::CTRL_CYCLIC];

  // start-up sequencer
  pspc_state_e          state_r, state_nxt;
  wire cfg_wr = apb_wr & hit_pcfg & (state_r == ST_RUN);
  pspc_pkg::pspc_sw_s   deb_r, sw_r;
  logic [3:0]           deb_cnt_r;
  logic                 stored_r;
  pspc_pkg::pspc_proto_e proto_r;
  logic [31:0]          tick_cnt_r;
  logic [2:0]           halves_r;
  logic                 blink_r;
  wire  pspc_pkg::pspc_proto_e sw_proto = decode(sw_r);
  wire  digits_ok = (sw_r.tens <= pspc_pkg::DIGIT_MAX) && (sw_r.units <= pspc_pkg::DIGIT_MAX);
  wire  sw_valid  = (sw_proto != pspc_pkg::PR_NONE) && (!uses_ip(sw_proto) || digits_ok);
  wire  is_frst   = sw_r == pspc_pkg::SW_FRST;
  wire  deb_done  = deb_cnt_r == pspc_pkg::DEB_N;
  wire  tick      = tick_cnt_r == BLINK_CYC - 1;
  wire  err_done  = tick && (halves_r == pspc_pkg::ERR_HALVES - 3'h1);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_DEB: begin
        if (deb_done) begin
          state_nxt = ST_DEC;
        end
      end
      ST_DEC: begin
        if (is_frst) begin
          state_nxt = ST_FRST;
        end else if (NV_PROTO_VALID || sw_valid) begin
          state_nxt = ST_RUN;
        end else begin
          state_nxt = ST_ERR;
        end
      end
      ST_FRST: begin
        if (NV_DONE) begin
          state_nxt = ST_RUN;
        end
      end
      ST_ERR: begin
        if (err_done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_DEB;
      end
    endcase
    if (web_rst) begin
      state_nxt = ST_DEB;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_r <= ST_DEB;
    end else begin
      state_r <= state_nxt;
    end
  end

  // consecutive equal samples; the running device never looks at the switches
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      deb_r     <= '0;
      deb_cnt_r <= 4'h0;
      sw_r      <= '0;
    end else if (state_r == ST_DEB) begin
      if (deb_done) begin
        sw_r <= deb_r;
      end else if (sw_s2_r == sw_s3_r) begin
        deb_r <= sw_s3_r;
        if (sw_s3_r != deb_r) begin
          deb_cnt_r <= 4'h0;
        end else begin
          deb_cnt_r <= deb_cnt_r + 4'h1;
        end
      end
    end else begin
      deb_cnt_r <= 4'h0;
    end
  end

  // protocol choice: stored one wins over the switch
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      proto_r        <= pspc_pkg::PR_NONE;
      stored_r       <= 1'b0;
      NV_WR_PROTO    <= 1'b0;
      NV_PROTO_WDATA <= pspc_pkg::PR_NONE;
      NV_ERASE       <= 1'b0;
    end else begin
      NV_WR_PROTO <= 1'b0;
      NV_ERASE    <= 1'b0;
      if (state_r == ST_DEC) begin
        if (is_frst) begin
          proto_r  <= pspc_pkg::PR_NONE;
          stored_r <= 1'b0;
          NV_ERASE <= 1'b1;
        end else if (NV_PROTO_VALID) begin
          proto_r  <= NV_PROTO;
          stored_r <= 1'b1;
        end else begin
          proto_r  <= sw_valid ? sw_proto : pspc_pkg::PR_NONE;
          stored_r <= 1'b0;
        end
      end else if (cyc_strt && state_r == ST_RUN && !stored_r && proto_r != pspc_pkg::PR_NONE) begin
        stored_r       <= 1'b1;
        NV_WR_PROTO    <= 1'b1;
        NV_PROTO_WDATA <= proto_r;
      end
    end
  end

  // address digits only for protocols that take them
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      IP_DIGITS <= '0;
      IP_VALID  <= 1'b0;
    end else if (state_r == ST_DEC) begin
      IP_DIGITS <= sw_r;
      IP_VALID  <= sw_valid && uses_ip(sw_proto) && !is_frst && !NV_PROTO_VALID;
    end
  end

  // shared blink timebase
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tick_cnt_r <= 32'h0;
      halves_r   <= 3'h0;
      blink_r    <= 1'b0;
    end else if (state_r == ST_ERR || state_r == ST_FRST) begin
      if (tick) begin
        tick_cnt_r <= 32'h0;
        halves_r   <= halves_r + 3'h1;
        blink_r    <= ~blink_r;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h1;
      end
    end else begin
      tick_cnt_r <= 32'h0;
      halves_r   <= 3'h0;
      blink_r    <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      FAULT_STATUS_LED_RED <= 1'b0;
      SUPPLY_LED_RED       <= 1'b0;
      SUPPLY_LED_GREEN     <= 1'b0;
      PROTO_ACTIVE         <= pspc_pkg::PR_NONE;
    end else begin
      FAULT_STATUS_LED_RED <= (state_r == ST_ERR) && !blink_r;
      if (state_r == ST_FRST) begin
        SUPPLY_LED_RED   <= !blink_r;
        SUPPLY_LED_GREEN <= 1'b0;
      end else begin
        SUPPLY_LED_RED   <= !us_r;
        SUPPLY_LED_GREEN <= us_r;
      end
      PROTO_ACTIVE <= (state_r == ST_RUN) ? proto_r : pspc_pkg::PR_NONE;
    end
  end

  // port modes; stored set is applied before the controller speaks
  pspc_pkg::pspc_cfg_s [7:0] cfg_r;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cfg_r           <= {pspc_pkg::NPORT{pspc_pkg::CFG_RST}};
      PORT_DATA_VALID <= 1'b0;
      NV_WR_CFG       <= 1'b0;
    end else begin
      NV_WR_CFG <= 1'b0;
      if (state_r == ST_DEC) begin
        PORT_DATA_VALID <= 1'b0;
        if (is_frst) begin
          cfg_r <= {pspc_pkg::NPORT{pspc_pkg::CFG_RST}};
        end else if (NV_CFG_VALID) begin
          cfg_r <= NV_CFG;
        end
      end else if (cfg_wr && cfg_ok) begin
        cfg_r[pcfg_idx] <= wr_cfg;
        PORT_DATA_VALID <= 1'b1;
        NV_WR_CFG       <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PORT_CFG       <= {pspc_pkg::NPORT{pspc_pkg::CFG_RST}};
      NV_CFG_WDATA   <= {pspc_pkg::NPORT{pspc_pkg::CFG_RST}};
      PORT_SUPPLY_EN <= 8'h00;
      PORT_IOL_START <= 8'h00;
    end else begin
      PORT_CFG     <= cfg_r;
      NV_CFG_WDATA <= cfg_r;
      for (int i = 0; i < pspc_pkg::NPORT; i++) begin
        PORT_SUPPLY_EN[i] <= (state_r == ST_RUN) && (cfg_r[i].mode != pspc_pkg::MD_OFF);
        PORT_IOL_START[i] <= (state_r == ST_RUN) && (cfg_r[i].mode == pspc_pkg::MD_IOL);
      end
    end
  end

  // interrupt status: set beats the read-clear
  logic [pspc_pkg::IRQ_W-1:0] irqs_r, irqm_r;
  wire  [pspc_pkg::IRQ_W-1:0] irq_set;
  assign irq_set[pspc_pkg::IRQ_SWERR]  = (state_r == ST_DEC) && (state_nxt == ST_ERR);
  assign irq_set[pspc_pkg::IRQ_FRDONE] = (state_r == ST_FRST) && NV_DONE;
  assign irq_set[pspc_pkg::IRQ_STORED] = NV_WR_PROTO;
  assign irq_set[pspc_pkg::IRQ_CFGOK]  = cfg_wr && cfg_ok;
  assign irq_set[pspc_pkg::IRQ_CFGBAD] = cfg_wr && !cfg_ok;
  wire irqs_clr = apb_rd & hit_irqs;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      irqs_r <= '0;
      irqm_r <= '0;
      IRQ    <= 1'b0;
    end else begin
      irqs_r <= (irqs_clr ? '0 : irqs_r) | irq_set;
      if (apb_wr && hit_irqm) begin
        irqm_r <= PWDATA[pspc_pkg::IRQ_W-1:0];
      end
      IRQ <= |(irqs_r & irqm_r);
    end
  end

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_stat) begin
      rd_mux = {16'h0, 3'h0, PORT_DATA_VALID, stored_r, proto_r, 5'h0, state_r};
    end else if (hit_irqs) begin
      rd_mux[pspc_pkg::IRQ_W-1:0] = irqs_r;
    end else if (hit_irqm) begin
      rd_mux[pspc_pkg::IRQ_W-1:0] = irqm_r;
    end else if (hit_ip) begin
      rd_mux = {19'h0, IP_VALID, IP_DIGITS};
    end else if (hit_pcfg) begin
      rd_mux[pspc_pkg::PCFG_MODE_LSB +: 2] = cfg_r[pcfg_idx].mode;
      rd_mux[pspc_pkg::PCFG_IN_LSB +: 6]   = cfg_r[pcfg_idx].in_len;
      rd_mux[pspc_pkg::PCFG_OUT_LSB +: 6]  = cfg_r[pcfg_idx].out_len;
    end
  end

  // no wait state; read data and the answer still leave flip-flops
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= apb_setup;
      PRDATA  <= apb_setup ? rd_mux : 32'h0;
      PSLVERR <= apb_setup & ~hit_any;
    end
  end

endmodule : pspc_top
`default_nettype wire

/* File: pspc_pkg.sv */
// constants, types and register map of the protocol select and port config block
// assumes an apb master, a same-clock nonvolatile store and pins for switches and leds
// Notes on behaviour
// - hundreds switch 0-2 selects ethernet/ip, ip hundreds
// - tens and units give last ip digits
// - position p selects profinet, address switches ignored
// - switches taken only at reset or web reset
// - no stored protocol: use switch protocol
// - store protocol at cyclic start, then reuse
// - invalid switches: fault led blinks red thrice
// - code 9-7-9 restores factory settings, clears protocol
// - supply led blinks red until erase done
// - modes in, out, off, io-link; off cuts supply
// - every port defaults to digital input
// - ports one to eight at sub-slots 2-9
// - io-link lengths 1-33 in, 1-32 out
// - io-link mode starts link without command
// - stored port config applied at power-up
// - process data invalid until new config arrives
package pspc_pkg;
  typedef enum logic [2:0] {
    PR_NONE = 3'h0,
    PR_EIP  = 3'h1,
    PR_PN   = 3'h2,
    PR_EC   = 3'h3,
    PR_MB   = 3'h4,
    PR_CC   = 3'h5
  } pspc_proto_e;
  typedef enum logic [1:0] {
    MD_DI  = 2'h0,
    MD_DO  = 2'h1,
    MD_OFF = 2'h2,
    MD_IOL = 2'h3
  } pspc_mode_e;
  typedef struct packed {
    pspc_mode_e mode;
    logic [5:0] in_len;
    logic [5:0] out_len;
  } pspc_cfg_s;
  typedef struct packed {
    logic [3:0] hund;
    logic [3:0] tens;
    logic [3:0] units;
  } pspc_sw_s;
  localparam int NPORT = 8;
  localparam logic [3:0] POS_EIP_MAX = 4'h2;
  localparam logic [3:0] POS_PN      = 4'h3;
  localparam logic [3:0] POS_EC      = 4'h4;
  localparam logic [3:0] POS_MB      = 4'h5;
  localparam logic [3:0] POS_CC      = 4'h6;
  localparam logic [3:0] DIGIT_MAX   = 4'h9;
  localparam pspc_sw_s   SW_FRST     = '{4'h9, 4'h7, 4'h9};
  localparam logic [5:0] IN_LEN_MAX  = 6'h21;
  localparam logic [5:0] OUT_LEN_MAX = 6'h20;
  localparam logic [5:0] LEN_MIN     = 6'h01;
  localparam pspc_cfg_s  CFG_RST     = '{MD_DI, 6'h00, 6'h00};
  localparam logic [3:0] SUBSLOT_FIRST = 4'h2;
  localparam logic [3:0] DEB_N       = 4'h8;
  localparam int BLINK_MS      = 250;
  localparam int CLK_KHZ       = 100000;
  localparam int BLINK_CYC     = BLINK_MS * CLK_KHZ;
  localparam logic [2:0] ERR_HALVES = 3'h6;
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_STAT  = 12'h004;
  localparam logic [11:0] A_IRQS  = 12'h008;
  localparam logic [11:0] A_IRQM  = 12'h00c;
  localparam logic [11:0] A_IPADR = 12'h010;
  localparam logic [11:0] A_PCFG  = 12'h020;
  localparam int CTRL_WEBRST = 0;
  localparam int CTRL_CYCLIC = 1;
  localparam int PCFG_MODE_LSB = 0;
  localparam int PCFG_IN_LSB   = 8;
  localparam int PCFG_OUT_LSB  = 16;
  localparam int IRQ_W       = 5;
  localparam int IRQ_SWERR   = 0;
  localparam int IRQ_FRDONE  = 1;
  localparam int IRQ_STORED  = 2;
  localparam int IRQ_CFGOK   = 3;
  localparam int IRQ_CFGBAD  = 4;
endpackage : pspc_pkg

/* File: pspc_nv_model.sv */
// behavioural nonvolatile store beside the block
// assumes the block's clock and config write data lagging its strobe by one cycle
`timescale 1ns/1ns
`default_nettype none
module pspc_nv_model #(
  parameter int ERASE_CYC = 40
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      wr_proto,
  input  wire pspc_pkg::pspc_proto_e     proto_wdata,
  input  wire logic                      wr_cfg,
  input  wire pspc_pkg::pspc_cfg_s [7:0] cfg_wdata,
  input  wire logic                      erase,
  output pspc_pkg::pspc_proto_e          proto,
  output logic                           proto_valid,
  output pspc_pkg::pspc_cfg_s [7:0]      cfg,
  output logic                           cfg_valid,
  output logic                           done
);
  logic cfg_pend_r;
  int   erase_cnt_r;
  // contents ignore rst on purpose: a store keeps its data over a power cycle
  initial begin
    proto = pspc_pkg::PR_NONE;
    proto_valid = 1'h0;
    cfg = '0;
    cfg_valid = 1'h0;
    done = 1'h0;
    cfg_pend_r = 1'h0;
    erase_cnt_r = 0;
  end
  always @(posedge clk) begin
    cfg_pend_r <= wr_cfg && !rst;
    if (wr_proto) begin
      proto <= proto_wdata;
      proto_valid <= 1'h1;
    end
    if (cfg_pend_r) begin
      cfg <= cfg_wdata;
      cfg_valid <= 1'h1;
    end
    if (erase) begin
      proto_valid <= 1'h0;
      cfg_valid <= 1'h0;
      done <= 1'h0;
      erase_cnt_r <= ERASE_CYC;
    end else if (erase_cnt_r == 1) begin
      done <= 1'h1;
      erase_cnt_r <= 0;
    end else if (erase_cnt_r > 1) begin
      erase_cnt_r <= erase_cnt_r - 1;
    end
  end
endmodule : pspc_nv_model
`default_nettype wire

/* File: pspc_chk.sv */
// concurrent checks on the ports of pspc_top
// assumes one clock domain and reset RST active high
`timescale 1ns/1ns
`default_nettype none
module pspc_chk (
  input wire logic                      CORE_CLK,
  input wire logic                      RST,
  input wire logic                      PSEL,
  input wire logic                      PENABLE,
  input wire logic                      PWRITE,
  input wire logic                      PREADY,
  input wire pspc_pkg::pspc_proto_e     PROTO_ACTIVE,
  input wire pspc_pkg::pspc_sw_s        IP_DIGITS,
  input wire logic                      IP_VALID,
  input wire pspc_pkg::pspc_cfg_s [7:0] PORT_CFG,
  input wire logic [7:0]                PORT_SUPPLY_EN,
  input wire logic [7:0]                PORT_IOL_START,
  input wire logic                      PORT_DATA_VALID,
  input wire logic                      NV_WR_PROTO,
  input wire pspc_pkg::pspc_proto_e     NV_PROTO_WDATA,
  input wire logic                      NV_ERASE,
  input wire logic                      FAULT_STATUS_LED_RED
);
  logic wr_acc;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_ready;
    PSEL && !PENABLE |=> PREADY ##1 !PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer not a single cycle after setup");
  property p_eip;
    IP_VALID && PROTO_ACTIVE == pspc_pkg::PR_EIP |-> IP_DIGITS.hund <= pspc_pkg::POS_EIP_MAX;
  endproperty
  a_eip: assert property (p_eip) else $error("eip with hundreds digit above two");
  property p_digits;
    IP_VALID |-> IP_DIGITS.tens <= pspc_pkg::DIGIT_MAX && IP_DIGITS.units <= pspc_pkg::DIGIT_MAX;
  endproperty
  a_digits: assert property (p_digits) else $error("address digit above nine");
  property p_pn;
    PROTO_ACTIVE == pspc_pkg::PR_PN && $past(PROTO_ACTIVE) == pspc_pkg::PR_PN |-> !IP_VALID;
  endproperty
  a_pn: assert property (p_pn) else $error("switch address used under profinet");
  property p_hold;
    PROTO_ACTIVE != pspc_pkg::PR_NONE |=> $stable(PROTO_ACTIVE) || PROTO_ACTIVE == pspc_pkg::PR_NONE;
  endproperty
  a_hold: assert property (p_hold) else $error("protocol changed while running");
  property p_store;
    NV_WR_PROTO |-> NV_PROTO_WDATA == PROTO_ACTIVE && PROTO_ACTIVE != pspc_pkg::PR_NONE ##1 !NV_WR_PROTO;
  endproperty
  a_store: assert property (p_store) else $error("bad protocol store pulse");
  property p_erase;
    NV_ERASE |-> PROTO_ACTIVE == pspc_pkg::PR_NONE ##1 !NV_ERASE;
  endproperty
  a_erase: assert property (p_erase) else $error("bad erase pulse");
  property p_off;
    PORT_SUPPLY_EN[7] |-> PORT_CFG[7].mode != pspc_pkg::MD_OFF || $past(PORT_CFG[7].mode) != pspc_pkg::MD_OFF;
  endproperty
  a_off: assert property (p_off) else $error("supply on in deactivated port");
  property p_iol;
    PORT_IOL_START[0] |-> PORT_CFG[0].mode == pspc_pkg::MD_IOL || $past(PORT_CFG[0].mode) == pspc_pkg::MD_IOL;
  endproperty
  a_iol: assert property (p_iol) else $error("link start outside io-link mode");
  property p_valid;
    $rose(PORT_DATA_VALID) |-> $past(wr_acc, 1) || $past(wr_acc, 2);
  endproperty
  a_valid: assert property (p_valid) else $error("data valid without config write");
  c_fault: cover property ($rose(FAULT_STATUS_LED_RED));
  c_erase: cover property (NV_ERASE);
  c_store: cover property (NV_WR_PROTO);
  c_valid: cover property ($rose(PORT_DATA_VALID));
endmodule : pspc_chk
bind pspc_top pspc_chk u_chk (.*);
`default_nettype wire

/* File: tb.sv */
// self-checking bench: apb controller, switch pins and store model around pspc_top
// assumes BLINK_CYC set to 4 so blink codes stay short
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                      CORE_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, US_OK;
  logic [11:0]               PADDR;
  logic [31:0]               PWDATA, PRDATA, rd;
  pspc_pkg::pspc_sw_s        SWITCHES, IP_DIGITS;
  pspc_pkg::pspc_proto_e     NV_PROTO, NV_PROTO_WDATA, PROTO_ACTIVE;
  pspc_pkg::pspc_cfg_s [7:0] NV_CFG, NV_CFG_WDATA, PORT_CFG;
  logic                      NV_PROTO_VALID, NV_CFG_VALID, NV_DONE, NV_WR_PROTO, NV_WR_CFG, NV_ERASE;
  logic                      IP_VALID, PORT_DATA_VALID, FAULT_STATUS_LED_RED, SUPPLY_LED_RED;
  logic                      SUPPLY_LED_GREEN, IRQ, er, sup_red;
  logic [7:0]                PORT_SUPPLY_EN, PORT_IOL_START;
  int                        fails, total_checks, blinks, i;
  pspc_pkg::pspc_proto_e     exp_p [7] = '{pspc_pkg::PR_EIP, pspc_pkg::PR_EIP, pspc_pkg::PR_EIP,
    pspc_pkg::PR_PN, pspc_pkg::PR_EC, pspc_pkg::PR_MB, pspc_pkg::PR_CC};
  pspc_top #(.BLINK_CYC(4)) DUT (.*);
  pspc_nv_model NV (.clk(CORE_CLK), .rst(RST), .wr_proto(NV_WR_PROTO), .proto_wdata(NV_PROTO_WDATA),
    .wr_cfg(NV_WR_CFG), .cfg_wdata(NV_CFG_WDATA), .erase(NV_ERASE), .proto(NV_PROTO),
    .proto_valid(NV_PROTO_VALID), .cfg(NV_CFG), .cfg_valid(NV_CFG_VALID), .done(NV_DONE));
  always #5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    if ($rose(FAULT_STATUS_LED_RED)) blinks <= blinks + 1;
    if (SUPPLY_LED_RED) sup_red <= 1'h1;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // ready is read right after the edge, i.e. the value sampled at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'h1;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
      if (n > 16) begin
        fails++;
        finish_test();
      end
    end while (PREADY !== 1'h1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CORE_CLK);
  endtask : apb
  task automatic wait_run();
    for (int n = 0; n < 80; n++) begin
      apb(1'h0, pspc_pkg::A_STAT, 32'h0);
      if (rd[2:0] === 3'h3) return;
    end
    fails++;
    finish_test();
  endtask : wait_run
  task automatic restart(input pspc_pkg::pspc_sw_s s);
    SWITCHES <= s;
    repeat (5) @(posedge CORE_CLK);
    apb(1'h1, pspc_pkg::A_CTRL, 32'h1);
    wait_run();
    repeat (3) @(posedge CORE_CLK);
  endtask : restart
  task automatic t_boot();
    chk(PROTO_ACTIVE, pspc_pkg::PR_EIP);
    chk(IP_DIGITS, 12'h123);
    chk(IP_VALID, 1'h1);
    for (i = 0; i < 8; i++) chk(PORT_CFG[i], pspc_pkg::CFG_RST);
    chk(PORT_DATA_VALID, 1'h0);
  endtask : t_boot
  task automatic t_hold();
    SWITCHES <= '{pspc_pkg::POS_PN, 4'h5, 4'h6};
    repeat (20) @(posedge CORE_CLK);
    chk(PROTO_ACTIVE, pspc_pkg::PR_EIP);
    chk(IP_DIGITS, 12'h123);
    restart('{pspc_pkg::POS_PN, 4'h5, 4'h6});
    chk(PROTO_ACTIVE, pspc_pkg::PR_PN);
    chk(IP_VALID, 1'h0);
  endtask : t_hold
  task automatic t_cfg();
    apb(1'h1, pspc_pkg::A_IRQM, 32'h8);
    apb(1'h1, pspc_pkg::A_PCFG + 12'h4, 32'h00012203);
    repeat (2) @(posedge CORE_CLK);
    chk(PORT_CFG[1], pspc_pkg::CFG_RST);
    chk(IRQ, 1'h0);
    apb(1'h1, pspc_pkg::A_PCFG, 32'h00202103);
    repeat (2) @(posedge CORE_CLK);
    chk(PORT_CFG[0], {pspc_pkg::MD_IOL, 6'h21, 6'h20});
    chk(PORT_IOL_START, 8'h01);
    chk(PORT_DATA_VALID, 1'h1);
    chk(IRQ, 1'h1);
    apb(1'h1, pspc_pkg::A_PCFG + 12'h1c, 32'h2);
    apb(1'h1, pspc_pkg::A_PCFG + 12'h8, 32'h1);
    repeat (2) @(posedge CORE_CLK);
    chk(PORT_CFG[7].mode, pspc_pkg::MD_OFF);
    chk(PORT_CFG[2].mode, pspc_pkg::MD_DO);
    chk(PORT_SUPPLY_EN, 8'h7f);
    apb(1'h0, pspc_pkg::A_PCFG + 12'h1c, 32'h0);
    chk(rd, 32'h2);
    apb(1'h0, pspc_pkg::A_IRQS, 32'h0);
    chk(rd, 32'h18);
    repeat (2) @(posedge CORE_CLK);
    chk(IRQ, 1'h0);
    apb(1'h0, 12'h100, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
  endtask : t_cfg
  task automatic t_store();
    apb(1'h1, pspc_pkg::A_CTRL, 32'h2);
    repeat (3) @(posedge CORE_CLK);
    chk({NV_PROTO_VALID, NV_PROTO}, {1'h1, pspc_pkg::PR_PN});
    restart('{4'h0, 4'h1, 4'h2});
    chk(PROTO_ACTIVE, pspc_pkg::PR_PN);
    chk(PORT_CFG[0].mode, pspc_pkg::MD_IOL);
    chk(PORT_SUPPLY_EN[7], 1'h0);
    chk(PORT_DATA_VALID, 1'h0);
  endtask : t_store
  task automatic t_factory();
    sup_red = 1'h0;
    restart(pspc_pkg::SW_FRST);
    chk(sup_red, 1'h1);
    chk(NV_PROTO_VALID, 1'h0);
    chk(PROTO_ACTIVE, pspc_pkg::PR_NONE);
    chk(PORT_CFG[0], pspc_pkg::CFG_RST);
    chk({SUPPLY_LED_RED, SUPPLY_LED_GREEN}, 2'h1);
    US_OK <= 1'h0;
    repeat (8) @(posedge CORE_CLK);
    chk({SUPPLY_LED_RED, SUPPLY_LED_GREEN}, 2'h2);
    US_OK <= 1'h1;
  endtask : t_factory
  task automatic t_modes();
    for (i = 0; i < 7; i++) begin
      restart('{i[3:0], 4'h4, 4'h2});
      chk(PROTO_ACTIVE, exp_p[i]);
      chk(IP_VALID, i != 3 && i != 4);
    end
  endtask : t_modes
  task automatic t_err();
    blinks = 0;
    restart('{4'h7, 4'h0, 4'h0});
    chk(blinks, 3);
    blinks = 0;
    restart('{4'h1, 4'ha, 4'h0});
    chk(blinks, 3);
    chk(PROTO_ACTIVE, pspc_pkg::PR_NONE);
    apb(1'h0, pspc_pkg::A_IRQS, 32'h0);
    chk(rd, 32'h7);
  endtask : t_err
  initial begin
    CORE_CLK = 1'h0;
    RST = 1'h1;
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    US_OK = 1'h1;
    SWITCHES = '{4'h1, 4'h2, 4'h3};
    fails = 0;
    total_checks = 0;
    blinks = 0;
    sup_red = 1'h0;
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'h0;
    wait_run();
    repeat (3) @(posedge CORE_CLK);
    t_boot();
    t_hold();
    t_cfg();
    t_store();
    t_factory();
    t_modes();
    t_err();
    finish_test();
  end
endmodule : tb
`default_nettype wire
